// File: common/mesc_pkg.sv
// package for the motion event status and configuration register bank
// assumes a byte-wide register port driven by the serial interface decoder
package mesc_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] WAKEUP_EVENT_SOURCE_ADDR = 8'h45;
   localparam logic [7:0] TAP_EVENT_SOURCE_ADDR = 8'h46;
   localparam logic [7:0] ORIENTATION_SOURCE_ADDR = 8'h47;
   localparam logic [7:0] FUNC_STATUS_SUMMARY_ADDR = 8'h49;
   localparam logic [7:0] STATE_MACHINE_STATUS_ADDR = 8'h4A;
   localparam logic [7:0] LEARNING_CORE_STATUS_ADDR = 8'h4B;
   localparam logic [7:0] FREQUENCY_TRIM_READOUT_ADDR = 8'h4F;
   localparam logic [7:0] FUNCTION_ENABLES_ADDR = 8'h50;
   localparam logic [7:0] INACTIVITY_CONFIG_ADDR = 8'h54;
   localparam logic [7:0] INACTIVITY_THRESHOLD_ADDR = 8'h55;
   localparam logic [7:0] TAP_FILTER_CONFIG_ADDR = 8'h56;
   localparam logic [7:0] TAP_PRIORITY_Z_THRESHOLD_ADDR = 8'h57;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] FUNCTION_ENABLES_RST = 8'h00;
   localparam logic [7:0] INACTIVITY_CONFIG_RST = 8'h04;
   localparam logic [7:0] INACTIVITY_THRESHOLD_RST = 8'h00;
   localparam logic [7:0] TAP_FILTER_CONFIG_RST = 8'h00;
   localparam logic [7:0] TAP_PRIORITY_Z_THRESHOLD_RST = 8'h00;
   // ************************************************************
   // writable bit masks (forced-zero bits never stored)
   // ************************************************************
   localparam logic [7:0] FUNCTION_ENABLES_MASK = 8'hCB;
   localparam logic [7:0] INACTIVITY_THRESHOLD_MASK = 8'h3F;
   localparam logic [7:0] TAP_FILTER_CONFIG_MASK = 8'h7F;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int FE_IRQ_ENABLE_BIT = 7;
   localparam int FE_TIMESTAMP_EN_BIT = 6;
   localparam int FE_KEEP_LATCHED_BIT = 3;
   localparam int FE_POWER_MODE_LSB = 0;
   localparam int IC_SLEEP_ON_PIN_BIT = 7;
   localparam int IC_WEIGHT_LSB = 4;
   localparam int IC_RATE_LSB = 2;
   localparam int IC_COUNT_LSB = 0;
   localparam int TC_ORIENT_FILT_BIT = 6;
   localparam int TC_SETTLE_MASK_BIT = 5;
   localparam int TC_MOTION_FILT_BIT = 4;
   localparam int TC_TAP_Z_EN_BIT = 3;
   localparam int TC_TAP_Y_EN_BIT = 2;
   localparam int TC_TAP_X_EN_BIT = 1;
   localparam int TC_LATCH_BIT = 0;
   localparam int TP_PRIORITY_LSB = 5;
   localparam int TP_LEVEL_Z_LSB = 0;
   // ************************************************************
   // modes and timing
   // ************************************************************
   localparam logic [1:0] PWR_INT_ONLY = 2'b00;
   localparam logic [1:0] PWR_XL_LOW = 2'b01;
   localparam logic [1:0] PWR_GYRO_SLEEP = 2'b10;
   localparam logic [1:0] PWR_GYRO_OFF = 2'b11;
   localparam int CLK_HZ = 125_000_000;
   localparam int TICK_HZ = 46_080;
   localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
   localparam logic [7:0] TRIM_RST = 8'h00;
endpackage : mesc_pkg

// File: hw/mesc_regs.sv
// register bank for motion event sources, embedded function status and
// basic motion function configuration
// assumes a single-cycle byte register port from the serial front end,
// event pulses synchronous to clk, and the trim value arriving from pins
`timescale 1ns/1ns
module mesc_regs
   import mesc_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // read of the all-source register elsewhere in the device
   input wire logic all_src_rd,
   // basic function events, one-cycle pulses from the detectors
   input wire logic settling,
   input wire logic wakeup_evt,
   input wire logic [2:0] wakeup_axes,
   input wire logic freefall_evt,
   input wire logic activity_change_evt,
   input wire logic sleep_state_in,
   input wire logic tap_single_evt,
   input wire logic tap_double_evt,
   input wire logic tap_sign_in,
   input wire logic [2:0] tap_axes,
   input wire logic orientation_evt,
   input wire logic [5:0] orientation_axes,
   // embedded function status levels
   input wire logic long_counter_timeout_flag,
   input wire logic significant_motion_flag,
   input wire logic incline_flag,
   input wire logic step_flag,
   input wire logic [7:0] fsm_irq,
   input wire logic [3:0] mlc_irq,
   // trim from the oscillator fuses
   input wire logic [7:0] rate_trim_in,
   // configuration outputs
   output logic basic_irq,
   output logic activity_pin,
   output logic [31:0] timestamp,
   output logic [1:0] inactivity_power_mode,
   output logic [2:0] threshold_weight,
   output logic [1:0] inactive_rate_sel,
   output logic [1:0] activity_entry_count,
   output logic [5:0] inactivity_level,
   output logic orientation_filter_sel,
   output logic motion_filter_sel,
   output logic [2:0] tap_axis_en,
   output logic [2:0] tap_priority,
   output logic [4:0] knock_level_z
);

   // ************************************************************
   // register map
   // ************************************************************
   // 0x45 wakeup source, read only
   //    bit 7 zero
   //    bit 6 activity change flag
   //    bit 5 freefall flag
   //    bit 4 sleep level, live
   //    bit 3 wakeup flag
   //    bits 2..0 axes z, y, x

   // 0x46 tap source, read only
   //    bit 7 any tap
   //    bit 6 single, bit 5 double
   //    bit 4 zero
   //    bit 3 sign, 1 negative
   //    bits 2..0 axes z, y, x

   // 0x47 orientation source
   //    bit 7 zero
   //    bit 6 change flag
   //    bits 5..0 high/low, x first

   // 0x49 embedded status, live
   //    bit 7 long counter timeout
   //    bit 5 motion, bit 4 incline
   //    bit 3 step, rest zero

   // 0x4A machine status, live
   // 0x4B core status, low nibble
   // 0x4F rate trim, signed

   // 0x50 function enables
   //    bit 7 basic irq enable
   //    bit 6 timestamp enable
   //    bit 3 keep latched flags
   //    bits 1..0 power mode
   //    bits 5, 4, 2 not stored

   // 0x54 inactivity config
   //    bit 7 sleep level on pin
   //    bits 6..4 weight
   //    bits 3..2 inactive rate
   //    bits 1..0 entry count

   // 0x55 level, bits 7..6 dropped

   // 0x56 tap filter config
   //    bit 7 not stored
   //    bit 6 orientation filter
   //    bit 5 settling mask
   //    bit 4 motion filter
   //    bits 3..1 tap axes z, y, x
   //    bit 0 latch mode

   // 0x57 priority 7..5, z level 4..0
   // other addresses read zero

   // ************************************************************
   // conventions
   // ************************************************************
   // events are one-cycle pulses;
   // a longer pulse counts once per cycle
   // axes and sign are taken only
   // with their own event pulse
   // status levels read as they
   // stand, never cleared here

   // ************************************************************
   // port timing
   // ************************************************************
   // a strobe is taken on the edge
   // where it is high; writes land
   // there and fields follow at once
   // read data stand until the
   // next read strobe
   // a source read clears at the
   // capturing edge, so the host
   // sees what it clears
   // back to back strobes are fine;
   // there are no wait states

   // reset: fields zero except the
   // inactive rate (15 Hz code)
   // reserved bits are masked on
   // write, so storage = readback

   // ************************************************************
   // configuration registers
   // ************************************************************
   logic [7:0] func_en_q;
   logic [7:0] inact_cfg_q;
   logic [7:0] inactivity_level_q;
   logic [7:0] tap_cfg_q;
   logic [7:0] tap_prio_q;

   // write strobes per register
   wire wr_func_en = reg_wr && (reg_addr == FUNCTION_ENABLES_ADDR);
   wire wr_inact_cfg = reg_wr && (reg_addr == INACTIVITY_CONFIG_ADDR);
   wire wr_inactivity_level = reg_wr && (reg_addr == INACTIVITY_THRESHOLD_ADDR);
   wire wr_tap_cfg = reg_wr && (reg_addr == TAP_FILTER_CONFIG_ADDR);
   wire wr_tap_prio = reg_wr && (reg_addr == TAP_PRIORITY_Z_THRESHOLD_ADDR);

   // forced-zero bits are dropped on write so they always read zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         func_en_q <= FUNCTION_ENABLES_RST;
         inact_cfg_q <= INACTIVITY_CONFIG_RST;
         inactivity_level_q <= INACTIVITY_THRESHOLD_RST;
         tap_cfg_q <= TAP_FILTER_CONFIG_RST;
         tap_prio_q <= TAP_PRIORITY_Z_THRESHOLD_RST;
      end else begin
         if (wr_func_en) func_en_q <= reg_wdata & FUNCTION_ENABLES_MASK;
         if (wr_inact_cfg) inact_cfg_q <= reg_wdata;
         if (wr_inactivity_level) inactivity_level_q <= reg_wdata & INACTIVITY_THRESHOLD_MASK;
         if (wr_tap_cfg) tap_cfg_q <= reg_wdata & TAP_FILTER_CONFIG_MASK;
         if (wr_tap_prio) tap_prio_q <= reg_wdata;
      end
   end

   // ************************************************************
   // field decode
   // ************************************************************
   wire irq_enable = func_en_q[FE_IRQ_ENABLE_BIT];
   wire timestamp_en = func_en_q[FE_TIMESTAMP_EN_BIT];
   wire keep_latched_on_read = func_en_q[FE_KEEP_LATCHED_BIT];
   wire sleep_on_pin = inact_cfg_q[IC_SLEEP_ON_PIN_BIT];
   wire settling_trigger_mask = tap_cfg_q[TC_SETTLE_MASK_BIT];
   wire irq_latch_mode = tap_cfg_q[TC_LATCH_BIT];

   assign inactivity_power_mode = func_en_q[FE_POWER_MODE_LSB +: 2];
   assign threshold_weight = inact_cfg_q[IC_WEIGHT_LSB +: 3];
   assign inactive_rate_sel = inact_cfg_q[IC_RATE_LSB +: 2];
   assign activity_entry_count = inact_cfg_q[IC_COUNT_LSB +: 2];
   assign inactivity_level = inactivity_level_q[5:0];
   assign orientation_filter_sel = tap_cfg_q[TC_ORIENT_FILT_BIT];
   assign motion_filter_sel = tap_cfg_q[TC_MOTION_FILT_BIT];
   // the host keeps these clear for axes it has disabled; no check here
   assign tap_axis_en = {tap_cfg_q[TC_TAP_Z_EN_BIT], tap_cfg_q[TC_TAP_Y_EN_BIT], tap_cfg_q[TC_TAP_X_EN_BIT]};
   assign tap_priority = tap_prio_q[TP_PRIORITY_LSB +: 3];
   assign knock_level_z = tap_prio_q[TP_LEVEL_Z_LSB +: 5];

   // ************************************************************
   // event gating and source flags
   // ************************************************************
   // basic events are dropped when disabled, or while data settle with the settling mask set
   wire evt_ok = irq_enable && !(settling_trigger_mask && settling);
   wire wu_set = evt_ok && wakeup_evt;
   wire ff_set = evt_ok && freefall_evt;
   wire ac_set = evt_ok && activity_change_evt;
   wire tap_set = evt_ok && (tap_single_evt || tap_double_evt);
   wire or_set = evt_ok && orientation_evt;

   // hazards of the event path:
   //  - an event in a clear cycle
   //    wins, so none is lost
   //  - pulsed mode keeps no
   //    history; slow hosts latch
   //  - disable gates new events
   //    only; held flags stay
   //  - settling masks triggers,
   //    not flags already held
   //  - sleep level is a state,
   //    it bypasses the latch
   //  - basic_irq is the OR of
   //    the stored event flags

   // source registers: latched mode holds until cleared, pulsed mode
   // shows the event for one cycle only; set beats clear
   logic [7:0] wu_src_q;
   logic [7:0] tap_event_source_q;
   logic [7:0] or_src_q;
   logic sleep_state_q;

   wire rd_wu = reg_rd && (reg_addr == WAKEUP_EVENT_SOURCE_ADDR);
   wire rd_tap = reg_rd && (reg_addr == TAP_EVENT_SOURCE_ADDR);
   wire rd_or = reg_rd && (reg_addr == ORIENTATION_SOURCE_ADDR);
   wire clr_all = all_src_rd && !keep_latched_on_read;
   wire hold = irq_latch_mode;

   // next values; bit 4 of the wakeup source is the live sleep level
   wire [7:0] wu_new = {1'b0, ac_set, ff_set, 1'b0, wu_set, wu_set ? wakeup_axes : 3'b000};
   wire [7:0] tap_new = {tap_set, tap_set && tap_single_evt, tap_set && tap_double_evt, 1'b0,
                         tap_set && tap_sign_in, tap_set ? tap_axes : 3'b000};
   wire [7:0] or_new = {1'b0, or_set, or_set ? orientation_axes : 6'b000000};
   wire [7:0] wu_d = (hold && !rd_wu && !clr_all) ? (wu_src_q | wu_new) : wu_new;
   wire [7:0] tap_d = (hold && !rd_tap && !clr_all) ? (tap_event_source_q | tap_new) : tap_new;
   wire [7:0] or_d = (hold && !rd_or && !clr_all) ? (or_src_q | or_new) : or_new;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wu_src_q <= 8'h00;
         tap_event_source_q <= 8'h00;
         or_src_q <= 8'h00;
         sleep_state_q <= 1'b0;
      end else begin
         wu_src_q <= wu_d;
         tap_event_source_q <= tap_d;
         or_src_q <= or_d;
         sleep_state_q <= sleep_state_in;
      end
   end

   // interrupt request and the activity pin view
   assign basic_irq = |{wu_src_q[6:5], wu_src_q[3], tap_event_source_q[7], or_src_q[6]};
   assign activity_pin = sleep_on_pin ? sleep_state_q : wu_src_q[6];

   // ************************************************************
   // timestamp counter
   // ************************************************************
   // wraps silently after 2^32
   // ticks; host tracks overflow
   // disable freezes the value
   // and restarts the divider
   // the tick divider ignores trim; trim is reported, not applied here
   logic [15:0] tick_cnt_q;
   logic [31:0] ts_q;
   wire tick = (tick_cnt_q == 16'(TICK_DIV - 1));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_q <= 16'h0000;
         ts_q <= 32'h0000_0000;
      end else if (!timestamp_en) begin
         tick_cnt_q <= 16'h0000;
      end else begin
         tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
         if (tick) ts_q <= ts_q + 32'h0000_0001;
      end
   end
   assign timestamp = ts_q;

   // ************************************************************
   // trim capture (pin input through two flops)
   // ************************************************************
   // fuse value from another
   // domain; settles long before
   // any host read
   logic [7:0] trim_s1_q;
   logic [7:0] trim_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trim_s1_q <= TRIM_RST;
         trim_q <= TRIM_RST;
      end else begin
         trim_s1_q <= rate_trim_in;
         trim_q <= trim_s1_q;
      end
   end

   // ************************************************************
   // read mux
   // ************************************************************
   // mode, weight, rate and count
   // go out uninterpreted; the
   // weight saturation lives in
   // the detector, not here
   // tap axis enables are stored
   // as written, not cross-checked
   wire [7:0] emb_stat = {long_counter_timeout_flag, 1'b0, significant_motion_flag, incline_flag,
                          step_flag, 3'b000};
   logic [7:0] rdata_d;
   always_comb begin
      case (reg_addr)
         WAKEUP_EVENT_SOURCE_ADDR: rdata_d = {wu_src_q[7:5], sleep_state_q, wu_src_q[3:0]};
         TAP_EVENT_SOURCE_ADDR: rdata_d = tap_event_source_q;
         ORIENTATION_SOURCE_ADDR: rdata_d = or_src_q;
         FUNC_STATUS_SUMMARY_ADDR: rdata_d = emb_stat;
         STATE_MACHINE_STATUS_ADDR: rdata_d = fsm_irq;
         LEARNING_CORE_STATUS_ADDR: rdata_d = {4'h0, mlc_irq};
         FREQUENCY_TRIM_READOUT_ADDR: rdata_d = trim_q;
         FUNCTION_ENABLES_ADDR: rdata_d = func_en_q;
         INACTIVITY_CONFIG_ADDR: rdata_d = inact_cfg_q;
         INACTIVITY_THRESHOLD_ADDR: rdata_d = inactivity_level_q;
         TAP_FILTER_CONFIG_ADDR: rdata_d = tap_cfg_q;
         TAP_PRIORITY_Z_THRESHOLD_ADDR: rdata_d = tap_prio_q;
         default: rdata_d = 8'h00;
      endcase
   end

   // read data registered on the read strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end
   end

endmodule : mesc_regs

// File: verification/mesc_regs_chk.sv
// checker for the motion event register bank, bound onto mesc_regs
// assumes one clock domain and the single-cycle register port
`timescale 1ns/1ns
module mesc_regs_chk
   import mesc_pkg::*;
#(parameter int TICK_DIV = 4) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic settling,
   input wire logic wakeup_evt,
   input wire logic freefall_evt,
   input wire logic activity_change_evt,
   input wire logic sleep_state_in,
   input wire logic tap_single_evt,
   input wire logic tap_double_evt,
   input wire logic orientation_evt,
   input wire logic [7:0] fsm_irq,
   input wire logic basic_irq,
   input wire logic activity_pin,
   input wire logic [31:0] timestamp,
   input wire logic [2:0] threshold_weight,
   input wire logic [1:0] inactive_rate_sel,
   input wire logic [1:0] activity_entry_count,
   input wire logic [2:0] tap_priority,
   input wire logic [4:0] knock_level_z
);
   logic [7:0] fe_q;
   logic [7:0] tc_q;
   logic mode_q;
   logic lat_p_q;
   wire ev_any = wakeup_evt | freefall_evt | activity_change_evt | tap_single_evt | tap_double_evt | orientation_evt;
   // shadow control bits, written at the same edge as the bank's own
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fe_q <= 8'h00;
         tc_q <= 8'h00;
         mode_q <= 1'b0;
         lat_p_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == FUNCTION_ENABLES_ADDR) fe_q <= reg_wdata;
         if (reg_wr && reg_addr == TAP_FILTER_CONFIG_ADDR) tc_q <= reg_wdata;
         if (reg_wr && reg_addr == INACTIVITY_CONFIG_ADDR) mode_q <= reg_wdata[7];
         lat_p_q <= tc_q[0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   irq_gate_a: assert property (!fe_q[7] && !basic_irq |=> !basic_irq)
      else $error("basic irq raised while disabled");
   wake_flag_a: assert property (fe_q[7] && !(tc_q[5] && settling) && wakeup_evt |=> basic_irq)
      else $error("wakeup event not flagged");
   settle_mask_a: assert property (tc_q[5] && settling && !basic_irq |=> !basic_irq)
      else $error("event passed while settling");
   pulse_irq_a: assert property ($rose(basic_irq) && !tc_q[0] && !lat_p_q && !ev_any |=> !basic_irq)
      else $error("pulsed flag held too long");
   sleep_pin_a: assert property (mode_q && $past(mode_q) |-> activity_pin == $past(sleep_state_in))
      else $error("pin does not follow sleep level");
   fsm_read_a: assert property (reg_rd && reg_addr == 8'h4A |=> reg_rdata == $past(fsm_irq))
      else $error("machine status read wrong");
   inact_cfg_a: assert property (reg_wr && reg_addr == 8'h54 |=>
      {threshold_weight, inactive_rate_sel, activity_entry_count} == $past(reg_wdata[6:0]))
      else $error("inactivity fields not stored");
   tap_cfg_a: assert property (reg_wr && reg_addr == 8'h57 |=> {tap_priority, knock_level_z} == $past(reg_wdata))
      else $error("tap fields not stored");
   ts_pause_a: assert property (!fe_q[6] |=> $stable(timestamp))
      else $error("timestamp moved while off");
endmodule : mesc_regs_chk
bind mesc_regs mesc_regs_chk #(.TICK_DIV(TICK_DIV)) u_chk (.*);

// File: verification/mesc_host.sv
// host model issuing single-cycle register strobes
// assumes the bank samples strobes on the rising clock edge
`timescale 1ns/1ns
module mesc_host (
   input wire logic clk,
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00
);
   // one strobe per access; idle bus shows inverted values, never stale ones
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
      @(posedge clk);
      #1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
   endtask : access
endmodule : mesc_host

// File: verification/mesc_regs_tb_top.sv
// self-checking bench for the motion event register bank
// assumes the host model and a tick divider shortened to 4
`timescale 1ns/1ns
module mesc_regs_tb_top
   import mesc_pkg::*;
;
   logic clk, reset_n, reg_wr, reg_rd, all_src_rd, settling, wakeup_evt, freefall_evt;
   logic activity_change_evt, sleep_state_in, tap_single_evt, tap_double_evt, tap_sign_in;
   logic orientation_evt, long_counter_timeout_flag, significant_motion_flag, incline_flag, step_flag;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, fsm_irq, rate_trim_in;
   logic [2:0] wakeup_axes, tap_axes, threshold_weight, tap_axis_en, tap_priority;
   logic [5:0] orientation_axes, inactivity_level;
   logic [3:0] mlc_irq;
   logic [1:0] inactivity_power_mode, inactive_rate_sel, activity_entry_count;
   logic [4:0] knock_level_z;
   logic [31:0] timestamp, ts_seen;
   logic basic_irq, activity_pin, orientation_filter_sel, motion_filter_sel;
   int num_errors = 0;
   int samples_checked = 0;
   mesc_regs #(.TICK_DIV(4)) i_dut (.*);
   mesc_host u_host (.*);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_host.access(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      u_host.access(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, reg_rdata});
   endtask : rd
   // bits: all-source read, orientation, double, single, change, freefall, wakeup
   task automatic fire(input logic [6:0] m);
      step();
      {all_src_rd, orientation_evt, tap_double_evt, tap_single_evt, activity_change_evt, freefall_evt, wakeup_evt} = m;
      step();
      {all_src_rd, orientation_evt, tap_double_evt, tap_single_evt, activity_change_evt, freefall_evt, wakeup_evt} = '0;
   endtask : fire
   task automatic t_reset();
      logic [7:0] adr [7] = '{8'h45, 8'h46, 8'h47, 8'h50, 8'h55, 8'h56, 8'h57};
      foreach (adr[i]) rd(adr[i], 8'h00);
      rd(8'h54, 8'h04);
      chk("timestamp", 32'h0, timestamp);
      $display("test reset done");
   endtask : t_reset
   task automatic t_cfg();
      for (int m = 0; m < 4; m++) begin
         wr(8'h50, 8'(m));
         chk("power mode", 32'(m), inactivity_power_mode);
      end
      wr(8'h50, 8'hFF);
      rd(8'h50, 8'hCB);
      wr(8'h50, 8'h00);
      wr(8'h54, 8'hD6);
      chk("weight", 32'h5, threshold_weight);
      chk("count", 32'h2, activity_entry_count);
      rd(8'h54, 8'hD6);
      chk("rate", 32'h1, inactive_rate_sel);
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h3F);
      chk("level", 32'h3F, inactivity_level);
      // z axis treated as powered down, so its tap enable stays clear
      wr(8'h56, 8'hD6);
      rd(8'h56, 8'h56);
      chk("filters", 32'h3, {orientation_filter_sel, motion_filter_sel});
      chk("tap axes", 32'h3, tap_axis_en);
      wr(8'h57, 8'hB5);
      rd(8'h57, 8'hB5);
      chk("tap prio", 32'h5, tap_priority);
      chk("knock z", 32'h15, knock_level_z);
      wr(8'h49, 8'hFF);
      rd(8'h49, 8'h00);
      rd(8'h60, 8'h00);
      $display("test config done");
   endtask : t_cfg
   task automatic t_status();
      {long_counter_timeout_flag, incline_flag, fsm_irq, mlc_irq, rate_trim_in} = {2'b11, 8'hA5, 4'h9, 8'h83};
      rd(8'h49, 8'h90);
      {long_counter_timeout_flag, incline_flag, significant_motion_flag, step_flag} = 4'b0011;
      rd(8'h49, 8'h28);
      rd(8'h4A, 8'hA5);
      rd(8'h4B, 8'h09);
      rd(8'h4F, 8'h83);
      $display("test status done");
   endtask : t_status
   task automatic t_events();
      {wakeup_axes, tap_sign_in, tap_axes, orientation_axes} = {3'b101, 1'b1, 3'b010, 6'b100100};
      wr(8'h50, 8'h80);
      wr(8'h56, 8'h01);
      fire(7'h01);
      chk("irq", 32'h1, basic_irq);
      rd(8'h45, 8'h0D);
      rd(8'h45, 8'h00);
      fire(7'h08);
      rd(8'h46, 8'hCA);
      tap_sign_in = 1'b0;
      fire(7'h10);
      rd(8'h46, 8'hA2);
      fire(7'h20);
      rd(8'h47, 8'h64);
      fire(7'h06);
      fire(7'h40);
      rd(8'h45, 8'h00);
      wr(8'h50, 8'h88);
      fire(7'h02);
      fire(7'h40);
      rd(8'h45, 8'h20);
      wr(8'h50, 8'h00);
      fire(7'h01);
      chk("irq off", 32'h0, basic_irq);
      wr(8'h50, 8'h80);
      wr(8'h56, 8'h21);
      settling = 1'b1;
      fire(7'h01);
      rd(8'h45, 8'h00);
      settling = 1'b0;
      wr(8'h56, 8'h00);
      fire(7'h01);
      chk("pulse high", 32'h1, basic_irq);
      step();
      chk("pulse low", 32'h0, basic_irq);
      sleep_state_in = 1'b1;
      step();
      step();
      chk("sleep pin", 32'h1, activity_pin);
      rd(8'h45, 8'h10);
      wr(8'h54, 8'h04);
      fire(7'h04);
      chk("change pin", 32'h1, activity_pin);
      step();
      chk("change pin low", 32'h0, activity_pin);
      $display("test events done");
   endtask : t_events
   task automatic t_ts();
      wr(8'h50, 8'h40);
      repeat (40) step();
      chk("ts running", 32'h1, 32'(timestamp inside {[8:11]}));
      wr(8'h50, 8'h00);
      step();
      ts_seen = timestamp;
      repeat (20) step();
      chk("ts held", ts_seen, timestamp);
      $display("test timestamp done");
   endtask : t_ts
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      wrap_up();
   end
   initial begin
      {reset_n, all_src_rd, settling, wakeup_evt, freefall_evt, activity_change_evt, sleep_state_in} = '0;
      {tap_single_evt, tap_double_evt, tap_sign_in, orientation_evt, long_counter_timeout_flag} = '0;
      {significant_motion_flag, incline_flag, step_flag, wakeup_axes, tap_axes, orientation_axes} = '0;
      {fsm_irq, mlc_irq, rate_trim_in} = '0;
      repeat (4) @(posedge clk);
      #1;
      reset_n = 1'b1;
      t_reset();
      t_cfg();
      t_status();
      t_events();
      t_ts();
      wrap_up();
   end
endmodule : mesc_regs_tb_top
